/* core/reset_strap_config_select.sv */
// strap capture at master reset release and start-up sequencing
`timescale 1ns/1ps
// Notes on behaviour
// - all gpio levels are caught at the release of master reset
// - captured gpio 9 picks the serial protocol: low spi, high i2c
// - every strap-derived setting can be rewritten by software afterwards
// - no pin in the address role gives address bit 2 zero
// - several address pins: only the highest-indexed one counts
// - the address strap does nothing when spi is chosen
// - a high eeprom-disable strap stops the eeprom fetch at start-up
// - with no eeprom-disable pin the eeprom search is attempted in i2c mode
// - several eeprom-disable pins are ored together
// - no config-select pins means gpio 3 to 0 form the index
// - strap pins pull up by default, so idle select pins give 15
// - index bits follow pin order, lowest pin is the lsb
// - fewer than four select pins leave upper index bits zero
// - more than four select pins give a wider index
// - the select strap picks the stored config, not on unprogrammed parts
// - pin roles come from the factory information block
// - defaults leave output clocks off and gpios as inputs
// - start-up loads config, enables regulators and clocks, calibrates and locks pll
// - a stored config with a bad checksum is not applied
// - the eeprom search is skipped in spi mode
module reset_strap_config_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_reset_n,
  input wire logic [strap_pkg::GPIO_N-1:0] gpio_in,
  input wire strap_pkg::roles_s roles,
  input wire logic roles_valid,
  input wire logic unprogrammed,
  input wire logic cfg_load_done,
  input wire logic cfg_checksum_ok,
  input wire logic pll_cal_done,
  input wire logic pll_locked,
  input wire logic eeprom_done,
  input wire logic sw_straps_we,
  input wire strap_pkg::straps_s sw_straps,
  input wire logic sw_out_clk_we,
  input wire logic [strap_pkg::OUT_CLK_N-1:0] sw_out_clk_en,
  input wire logic sw_gpio_we,
  input wire logic [strap_pkg::GPIO_N-1:0] sw_gpio_in_mode,
  input wire logic [strap_pkg::GPIO_N-1:0] sw_pull_up_en,
  output strap_pkg::straps_s straps,
  output logic [strap_pkg::GPIO_N-1:0] captured_pins,
  output logic [strap_pkg::GPIO_N-1:0] pull_up_en,
  output logic [strap_pkg::GPIO_N-1:0] gpio_in_mode,
  output logic [strap_pkg::OUT_CLK_N-1:0] out_clk_en,
  output logic cfg_load_req,
  output logic [strap_pkg::IDX_W-1:0] cfg_load_index,
  output logic cfg_applied,
  output logic regulator_en,
  output logic clocks_en,
  output logic pll_cal_start,
  output logic pll_lock_en,
  output logic eeprom_search_req,
  output logic seq_busy,
  output logic seq_done
);
  localparam int N = strap_pkg::GPIO_N;

  // pins and master reset come from outside: two flops before any use
  logic mr_s1_r;
  logic mr_s2_r;
  logic mr_prev_r;
  logic [N-1:0] pin_s1_r;
  logic [N-1:0] pin_s2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mr_s1_r <= 1'b0;
      mr_s2_r <= 1'b0;
      mr_prev_r <= 1'b0;
      pin_s1_r <= strap_pkg::PULL_UP_RESET;
      pin_s2_r <= strap_pkg::PULL_UP_RESET;
    end else begin
      mr_s1_r <= master_reset_n;
      mr_s2_r <= mr_s1_r;
      mr_prev_r <= mr_s2_r;
      pin_s1_r <= gpio_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // both paths have equal depth, so pins line up with the reset edge
  logic mr_rise;
  logic mr_low;
  assign mr_rise = mr_s2_r & ~mr_prev_r;
  assign mr_low = ~mr_s2_r;

  // capture and decode
  logic [N-1:0] cap_r;
  logic [N-1:0] cap_nxt;
  logic unprog_r;
  logic unprog_nxt;
  strap_pkg::straps_s dec_straps;

  always_comb begin
    cap_nxt = cap_r;
    unprog_nxt = unprog_r;
    if (mr_rise) begin
      cap_nxt = pin_s2_r;
      // an invalid information block behaves as unprogrammed
      unprog_nxt = unprogrammed | ~roles_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= strap_pkg::PULL_UP_RESET;
      unprog_r <= 1'b1;
    end else begin
      cap_r <= cap_nxt;
      unprog_r <= unprog_nxt;
    end
  end

  strap_decode u_decode (
    .pins(pin_s2_r),
    .roles(roles),
    .unprogrammed(unprogrammed | ~roles_valid),
    .straps(dec_straps)
  );

  // setting registers: straps load at release, software may overwrite later
  strap_pkg::straps_s straps_r;
  strap_pkg::straps_s straps_nxt;
  logic [strap_pkg::OUT_CLK_N-1:0] out_clk_r;
  logic [strap_pkg::OUT_CLK_N-1:0] out_clk_nxt;
  logic [N-1:0] in_mode_r;
  logic [N-1:0] in_mode_nxt;
  logic [N-1:0] pull_r;
  logic [N-1:0] pull_nxt;

  always_comb begin
    straps_nxt = straps_r;
    out_clk_nxt = out_clk_r;
    in_mode_nxt = in_mode_r;
    pull_nxt = pull_r;
    if (mr_rise) begin
      straps_nxt = dec_straps;
    end else if (sw_straps_we) begin
      straps_nxt = sw_straps;
    end
    if (sw_out_clk_we) begin
      out_clk_nxt = sw_out_clk_en;
    end
    if (sw_gpio_we) begin
      in_mode_nxt = sw_gpio_in_mode;
      pull_nxt = sw_pull_up_en;
    end
    // a new master reset puts pins back to pulled-up inputs, clocks off
    if (mr_low) begin
      out_clk_nxt = strap_pkg::OUT_CLK_EN_RESET;
      in_mode_nxt = strap_pkg::GPIO_IN_MODE_RESET;
      pull_nxt = strap_pkg::PULL_UP_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      straps_r <= '{proto_i2c: strap_pkg::PULL_UP_RESET[strap_pkg::PIN_PROTO],
                    addr_bit2: 1'b0, eeprom_dis: 1'b0,
                    cfg_index: strap_pkg::CFG_INDEX_RESET};
      out_clk_r <= strap_pkg::OUT_CLK_EN_RESET;
      in_mode_r <= strap_pkg::GPIO_IN_MODE_RESET;
      pull_r <= strap_pkg::PULL_UP_RESET;
    end else begin
      straps_r <= straps_nxt;
      out_clk_r <= out_clk_nxt;
      in_mode_r <= in_mode_nxt;
      pull_r <= pull_nxt;
    end
  end

  // start-up sequencer
  strap_pkg::seq_e st_r;
  strap_pkg::seq_e st_nxt;
  logic applied_r;
  logic applied_nxt;
  logic reg_en_r;
  logic reg_en_nxt;
  logic clk_en_r;
  logic clk_en_nxt;
  logic lock_en_r;
  logic lock_en_nxt;
  logic load_req_r;
  logic load_req_nxt;
  logic cal_r;
  logic cal_nxt;
  logic ee_req_r;
  logic ee_req_nxt;
  logic ee_allowed;

  // spi has no i2c master pins, so no search is possible then
  assign ee_allowed = straps_r.proto_i2c & ~straps_r.eeprom_dis;

  always_comb begin
    st_nxt = st_r;
    applied_nxt = applied_r;
    reg_en_nxt = reg_en_r;
    clk_en_nxt = clk_en_r;
    lock_en_nxt = lock_en_r;
    load_req_nxt = 1'b0;
    cal_nxt = 1'b0;
    ee_req_nxt = 1'b0;
    unique case (st_r)
      strap_pkg::S_HOLD: begin
        if (mr_rise) begin
          st_nxt = strap_pkg::S_CAPTURE;
        end
      end
      strap_pkg::S_CAPTURE: begin
        st_nxt = strap_pkg::S_LOAD_CFG;
      end
      strap_pkg::S_LOAD_CFG: begin
        if (unprog_r) begin
          st_nxt = strap_pkg::S_REG_EN;
        end else begin
          load_req_nxt = 1'b1;
          st_nxt = strap_pkg::S_WAIT_CFG;
        end
      end
      strap_pkg::S_WAIT_CFG: begin
        if (cfg_load_done) begin
          applied_nxt = cfg_checksum_ok;
          st_nxt = strap_pkg::S_REG_EN;
        end
      end
      strap_pkg::S_REG_EN: begin
        reg_en_nxt = 1'b1;
        st_nxt = strap_pkg::S_CLK_EN;
      end
      strap_pkg::S_CLK_EN: begin
        clk_en_nxt = 1'b1;
        cal_nxt = 1'b1;
        st_nxt = strap_pkg::S_PLL_CAL;
      end
      strap_pkg::S_PLL_CAL: begin
        if (pll_cal_done) begin
          lock_en_nxt = 1'b1;
          st_nxt = strap_pkg::S_PLL_LOCK;
        end
      end
      strap_pkg::S_PLL_LOCK: begin
        if (pll_locked) begin
          if (ee_allowed) begin
            ee_req_nxt = 1'b1;
            st_nxt = strap_pkg::S_EEPROM;
          end else begin
            st_nxt = strap_pkg::S_DONE;
          end
        end
      end
      strap_pkg::S_EEPROM: begin
        if (eeprom_done) begin
          st_nxt = strap_pkg::S_DONE;
        end
      end
      strap_pkg::S_DONE: begin
        st_nxt = strap_pkg::S_DONE;
      end
    endcase
    // master reset held low aborts any step and waits for release
    if (mr_low) begin
      st_nxt = strap_pkg::S_HOLD;
      applied_nxt = 1'b0;
      reg_en_nxt = 1'b0;
      clk_en_nxt = 1'b0;
      lock_en_nxt = 1'b0;
      load_req_nxt = 1'b0;
      cal_nxt = 1'b0;
      ee_req_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= strap_pkg::S_HOLD;
      applied_r <= 1'b0;
      reg_en_r <= 1'b0;
      clk_en_r <= 1'b0;
      lock_en_r <= 1'b0;
      load_req_r <= 1'b0;
      cal_r <= 1'b0;
      ee_req_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      applied_r <= applied_nxt;
      reg_en_r <= reg_en_nxt;
      clk_en_r <= clk_en_nxt;
      lock_en_r <= lock_en_nxt;
      load_req_r <= load_req_nxt;
      cal_r <= cal_nxt;
      ee_req_r <= ee_req_nxt;
    end
  end

  assign straps = straps_r;
  assign captured_pins = cap_r;
  assign pull_up_en = pull_r;
  assign gpio_in_mode = in_mode_r;
  assign out_clk_en = out_clk_r;
  assign cfg_load_req = load_req_r;
  assign cfg_load_index = straps_r.cfg_index;
  assign cfg_applied = applied_r;
  assign regulator_en = reg_en_r;
  assign clocks_en = clk_en_r;
  assign pll_cal_start = cal_r;
  assign pll_lock_en = lock_en_r;
  assign eeprom_search_req = ee_req_r;
  assign seq_busy = (st_r != strap_pkg::S_HOLD) && (st_r != strap_pkg::S_DONE);
  assign seq_done = (st_r == strap_pkg::S_DONE);
endmodule : reset_strap_config_select

/* common/strap_pkg.sv */
// shared constants, carriers and states for the reset strap loader
package strap_pkg;
  localparam int GPIO_N = 16;
  localparam int IDX_W = 16;
  localparam int POS_W = 5;
  localparam int OUT_CLK_N = 12;
  localparam int PIN_PROTO = 9;
  localparam logic [GPIO_N-1:0] DEF_CFG_MASK = 16'h000f;
  localparam logic [GPIO_N-1:0] PULL_UP_RESET = 16'hffff;
  localparam logic [GPIO_N-1:0] GPIO_IN_MODE_RESET = 16'hffff;
  localparam logic [OUT_CLK_N-1:0] OUT_CLK_EN_RESET = 12'h000;
  localparam logic [IDX_W-1:0] CFG_INDEX_RESET = 16'h000f;

  typedef struct packed {
    logic proto_i2c;
    logic addr_bit2;
    logic eeprom_dis;
    logic [IDX_W-1:0] cfg_index;
  } straps_s;

  typedef struct packed {
    logic [GPIO_N-1:0] addr_bit2_mask;
    logic [GPIO_N-1:0] eeprom_dis_mask;
    logic [GPIO_N-1:0] cfg_sel_mask;
  } roles_s;

  typedef enum logic [3:0] {
    S_HOLD = 4'h0,
    S_CAPTURE = 4'h1,
    S_LOAD_CFG = 4'h2,
    S_WAIT_CFG = 4'h3,
    S_REG_EN = 4'h4,
    S_CLK_EN = 4'h5,
    S_PLL_CAL = 4'h6,
    S_PLL_LOCK = 4'h7,
    S_EEPROM = 4'h8,
    S_DONE = 4'h9
  } seq_e;
endpackage : strap_pkg

/* core/strap_decode.sv */
// decodes captured pin levels into strap settings by role masks
`timescale 1ns/1ps
module strap_decode (
  input wire logic [strap_pkg::GPIO_N-1:0] pins,
  input wire strap_pkg::roles_s roles,
  input wire logic unprogrammed,
  output strap_pkg::straps_s straps
);
  localparam int N = strap_pkg::GPIO_N;
  logic [N-1:0] a2_mask;
  logic [N-1:0] ee_mask;
  logic [N-1:0] cfg_mask;
  logic [N:0] above;
  logic [N-1:0] a2_hit;
  logic [strap_pkg::POS_W-1:0] pos [0:N];
  logic [strap_pkg::IDX_W-1:0] idx;

  // unprogrammed parts keep the default role map
  assign a2_mask = unprogrammed ? '0 : roles.addr_bit2_mask;
  assign ee_mask = unprogrammed ? '0 : roles.eeprom_dis_mask;
  assign cfg_mask = (unprogrammed || roles.cfg_sel_mask == '0) ?
                    strap_pkg::DEF_CFG_MASK : roles.cfg_sel_mask;

  assign above[N] = 1'b0;
  assign pos[0] = '0;

  genvar i, j;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      assign above[i] = above[i+1] | a2_mask[i];
      assign a2_hit[i] = a2_mask[i] & ~above[i+1];
      assign pos[i+1] = pos[i] + strap_pkg::POS_W'(cfg_mask[i]);
    end
    for (j = 0; j < strap_pkg::IDX_W; j++) begin : g_bit
      logic [N-1:0] take;
      for (i = 0; i < N; i++) begin : g_src
        // unused upper bits stay zero when fewer pins are assigned
        assign take[i] = cfg_mask[i] & (pos[i] == strap_pkg::POS_W'(j)) & pins[i];
      end
      assign idx[j] = |take;
    end
  endgenerate

  always_comb begin
    straps.proto_i2c = pins[strap_pkg::PIN_PROTO];
    // no assigned pin leaves the bit at zero; spi ignores it
    straps.addr_bit2 = pins[strap_pkg::PIN_PROTO] & |(a2_hit & pins);
    straps.eeprom_dis = |(ee_mask & pins);
    straps.cfg_index = idx;
  end
endmodule : strap_decode

/* test/strap_board.sv */
// board side of the strap pins: drivers, resistors and device pulls
`timescale 1ns/1ps
module strap_board (
  input wire logic [strap_pkg::GPIO_N-1:0] drv_en,
  input wire logic [strap_pkg::GPIO_N-1:0] drv_val,
  input wire logic [strap_pkg::GPIO_N-1:0] pull_up_en,
  output logic [strap_pkg::GPIO_N-1:0] gpio
);
  // undriven pins other than gpio 8 settle to the device pull, never to a stale value; gpio 8 is tied high
  always_comb begin
    for (int i = 0; i < strap_pkg::GPIO_N; i++) begin
      gpio[i] = drv_en[i] ? drv_val[i] : pull_up_en[i];
    end
    gpio[8] = 1'b1;
  end
  // test-port pins are left off every strap role here
endmodule : strap_board

/* test/reset_strap_config_select_sva.sv */
// port assertions for the strap loader
`timescale 1ns/1ps
module reset_strap_config_select_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_reset_n,
  input wire strap_pkg::straps_s straps,
  input wire logic [strap_pkg::GPIO_N-1:0] captured_pins,
  input wire logic [strap_pkg::GPIO_N-1:0] gpio_in_mode,
  input wire logic [strap_pkg::OUT_CLK_N-1:0] out_clk_en,
  input wire logic cfg_load_req,
  input wire logic [strap_pkg::IDX_W-1:0] cfg_load_index,
  input wire logic cfg_applied,
  input wire logic regulator_en,
  input wire logic clocks_en,
  input wire logic pll_cal_start,
  input wire logic pll_lock_en,
  input wire logic eeprom_search_req,
  input wire logic seq_done,
  input wire logic sw_out_clk_we,
  input wire logic [strap_pkg::OUT_CLK_N-1:0] sw_out_clk_en,
  input wire logic unprogrammed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_req_pulse: assert property (cfg_load_req |=> !cfg_load_req)
    else $error("load request held too long");
  a_load_index: assert property (cfg_load_req |-> cfg_load_index == straps.cfg_index)
    else $error("load index differs from strap index");
  a_no_load_unprog: assert property (cfg_load_req |-> !unprogrammed)
    else $error("load requested on unprogrammed part");
  a_no_spi_search: assert property (eeprom_search_req |->
      straps.proto_i2c && !straps.eeprom_dis)
    else $error("eeprom search not allowed");
  a_spi_addr_zero: assert property ($changed(captured_pins) && !captured_pins[9] |->
      !straps.addr_bit2)
    else $error("address strap used in spi mode");
  a_capture_hold: assert property ($changed(captured_pins) |-> $past(master_reset_n))
    else $error("captured pins moved outside a capture");
  a_mr_defaults: assert property (!master_reset_n [*4] |->
      out_clk_en == '0 && gpio_in_mode == '1 && !regulator_en)
    else $error("defaults not applied in master reset");
  a_clk_with_cal: assert property ($rose(clocks_en) |-> pll_cal_start && regulator_en)
    else $error("clocks enabled out of order");
  a_done_all_on: assert property (seq_done |->
      regulator_en && clocks_en && pll_lock_en)
    else $error("done without enables");
  a_sw_clk_write: assert property (sw_out_clk_we && seq_done |->
      ##1 out_clk_en == $past(sw_out_clk_en))
    else $error("output clock write lost");
  c_applied: cover property (seq_done && cfg_applied);
  c_search: cover property (eeprom_search_req);
  c_spi: cover property ($changed(captured_pins) && !captured_pins[9]);
endmodule : reset_strap_config_select_sva

/* test/testbench.sv */
// self-checking bench for the reset strap loader
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic master_reset_n = 1'b0;
  logic cfg_load_done = 1'b0, cfg_checksum_ok = 1'b0, pll_cal_done = 1'b0;
  logic pll_locked = 1'b0, eeprom_done = 1'b0, roles_valid = 1'b0, unprogrammed = 1'b1;
  logic sw_straps_we = 1'b0, sw_out_clk_we = 1'b0, sw_gpio_we = 1'b0;
  strap_pkg::straps_s sw_straps = '0, straps;
  strap_pkg::roles_s roles = '0;
  logic [11:0] sw_out_clk_en = '0, out_clk_en;
  logic [15:0] sw_gpio_in_mode = '0, sw_pull_up_en = '0, drv_en = '0, drv_val = '0;
  logic [15:0] gpio_in, captured_pins, pull_up_en, gpio_in_mode, cfg_load_index;
  logic [15:0] ld_idx = '0;
  logic cfg_load_req, cfg_applied, regulator_en, clocks_en, pll_cal_start;
  logic pll_lock_en, eeprom_search_req, seq_busy, seq_done;
  int mismatches = 0, check_count = 0, n_ld = 0, n_ee = 0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (cfg_load_req === 1'b1) begin
      n_ld++;
      ld_idx = cfg_load_index;
    end
    if (eeprom_search_req === 1'b1) n_ee++;
  end
  strap_board strap_board_inst (.drv_en, .drv_val, .pull_up_en, .gpio(gpio_in));
  reset_strap_config_select reset_strap_config_select_inst (.clk, .rst_n, .master_reset_n,
    .gpio_in, .roles, .roles_valid, .unprogrammed, .cfg_load_done, .cfg_checksum_ok,
    .pll_cal_done, .pll_locked, .eeprom_done, .sw_straps_we, .sw_straps, .sw_out_clk_we,
    .sw_out_clk_en, .sw_gpio_we, .sw_gpio_in_mode, .sw_pull_up_en, .straps, .captured_pins,
    .pull_up_en, .gpio_in_mode, .out_clk_en, .cfg_load_req, .cfg_load_index, .cfg_applied,
    .regulator_en, .clocks_en, .pll_cal_start, .pll_lock_en, .eeprom_search_req, .seq_busy,
    .seq_done);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // acks arrive late on purpose, as levels the loader must wait for
  task automatic boot(input logic [15:0] en, input logic [15:0] val,
                      input strap_pkg::roles_s r, input logic u, input logic ok);
    int n;
    @(negedge clk);
    master_reset_n = 1'b0;
    {cfg_load_done, pll_cal_done, pll_locked, eeprom_done} = '0;
    drv_en = en;
    drv_val = val;
    roles = r;
    unprogrammed = u;
    roles_valid = !u;
    cfg_checksum_ok = ok;
    repeat (5) @(negedge clk);
    master_reset_n = 1'b1;
    n_ld = 0;
    n_ee = 0;
    repeat (8) @(negedge clk);
    chk(seq_busy, 1'b1);
    {cfg_load_done, pll_cal_done, pll_locked, eeprom_done} = '1;
    n = 0;
    while (seq_done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(seq_done, 1'b1);
    chk(seq_busy, 1'b0);
  endtask : boot
  task automatic t_default();
    boot(16'h0000, 16'h0000, '0, 1'b1, 1'b1);
    chk(straps, {3'b100, 16'h000f});
    chk(captured_pins, 16'hffff);
    chk(n_ld, 0);
    chk(cfg_applied, 1'b0);
    chk(n_ee, 1);
    $display("default straps done");
  endtask : t_default
  task automatic t_spi();
    boot(16'h0200, 16'h0000, '{16'h0020, 16'h0000, 16'h0000}, 1'b0, 1'b1);
    chk(straps, {3'b000, 16'h000f});
    chk(n_ee, 0);
    chk(n_ld, 1);
    chk(ld_idx, 16'h000f);
    chk(cfg_applied, 1'b1);
    $display("spi select done");
  endtask : t_spi
  task automatic t_roles();
    boot(16'h4444, 16'h0000, '{16'h5000, 16'h0c00, 16'h0164}, 1'b0, 1'b0);
    chk(straps, {3'b101, 16'h000a});
    chk(ld_idx, 16'h000a);
    chk(n_ee, 0);
    chk(cfg_applied, 1'b0);
    $display("role map done");
  endtask : t_roles
  task automatic t_width();
    boot(16'h0010, 16'h0000, '{16'h0080, 16'h0000, 16'h2012}, 1'b0, 1'b1);
    chk(straps, {3'b110, 16'h0005});
    chk(ld_idx, 16'h0005);
    chk(n_ee, 1);
    boot(16'h0020, 16'h0000, '{16'h0000, 16'h0000, 16'h003f}, 1'b0, 1'b1);
    chk(straps.cfg_index, 16'h001f);
    $display("index width done");
  endtask : t_width
  task automatic t_sw();
    @(negedge clk);
    {sw_straps_we, sw_out_clk_we, sw_gpio_we} = '1;
    sw_straps = {3'b001, 16'h1234};
    sw_out_clk_en = 12'h0a5;
    sw_gpio_in_mode = 16'h00f0;
    sw_pull_up_en = 16'h0f0f;
    @(negedge clk);
    {sw_straps_we, sw_out_clk_we, sw_gpio_we} = '0;
    chk(straps, {3'b001, 16'h1234});
    chk({out_clk_en, gpio_in_mode, pull_up_en}, {12'h0a5, 16'h00f0, 16'h0f0f});
    master_reset_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({out_clk_en, gpio_in_mode, pull_up_en}, {12'h000, 16'hffff, 16'hffff});
    chk(straps, {3'b001, 16'h1234});
    $display("software write done");
  endtask : t_sw
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_default();
    t_spi();
    t_roles();
    t_width();
    t_sw();
    test_done();
  end
endmodule : testbench
bind reset_strap_config_select reset_strap_config_select_sva sva_inst (.clk, .rst_n,
  .master_reset_n, .straps, .captured_pins, .gpio_in_mode, .out_clk_en, .cfg_load_req,
  .cfg_load_index, .cfg_applied, .regulator_en, .clocks_en, .pll_cal_start, .pll_lock_en,
  .eeprom_search_req, .seq_done, .sw_out_clk_we, .sw_out_clk_en, .unprogrammed);
